//--- core/wprl_cap_if.sv
// capture path between the wakeup core and the wake frame memory
`timescale 1ns/1ps
interface wprl_cap_if #(parameter int AW = 7, parameter int DW = 8);
   logic          wr;
   logic [AW-1:0] waddr;
   logic [DW-1:0] wdata;
   logic [AW-1:0] raddr;
   logic [DW-1:0] rdata;
   modport src (output wr, output waddr, output wdata, output raddr, input rdata);
   modport mem (input wr, input waddr, input wdata, input raddr, output rdata);
endinterface

//--- core/wprl_core.sv
// wakeup detection, pme signalling and power report data
`timescale 1ns/1ps
// Overview of operation
// - report byte content follows the 4-bit select: consumed, dissipated, common, reserved.
// - scale field: 0 unknown, 1 tenths, 2 hundredths, 3 thousandths of a watt.
// - with power management disabled the report byte reads zero.
// - select 0 or 4 returns the stored D0 power figure.
// - select 3 or 7 returns the D3 figure; other selects return zero.
// - a nonvolatile load copies the legacy wake enable into wake control.
// - legacy wake enabled means every received frame is checked for magic.
// - magic frame sets pme status; pme asserted only with assert-on-legacy or pme enable set.
// - accepted wake frame head goes to memory, its length to the length register.
// - magic frame sets the magic received flag.
// - legacy pme holds until flag cleared, assert bit cleared or wake disabled.
// - first captured frame is kept until software clears every frame received flag (bits 1 and up), not only the magic flag.
// - legacy wake works in all states; only nv load or software disables it.
// - acpi wake sources are magic frame, network wake frame and link change.
// - acpi wake frame must pass address filtering and an enabled filter.
// - acpi frame sets pme status, one flag per matching filter; pme needs enable.
// - enabled link change sets pme status and link flag; it asserts pme only with pme enable set.
// - acpi pme holds until pme status written one or pme enable written zero.
// - further wake frames ignored until every received flag is cleared.
// - link events ignored until the link changed flag is cleared.
// - each wake filter works only while its control bit is one.
// - wake pin pulses 50 ms, ignores magic frames meanwhile, re-pulses after.
// - pme status set on magic and link wakes regardless of enable, on acpi frames only with it; writing one clears it.
module wprl_core #(
   parameter int unsigned NUM_FILT        = wprl_pkg::NUM_FILT,
   parameter int unsigned WAKE_PIN_CYCLES = wprl_pkg::WAKE_PIN_CYCLES,
   parameter bit          HAS_WAKE_PIN    = 1'b1
) (
   input  wire logic                          sys_clk,
   input  wire logic                          rst,
   input  wire logic                          nv_load,
   input  wire logic                          nv_pm_enable,
   input  wire logic                          nv_legacy_wake_en,
   input  wire logic [wprl_pkg::DATA_W-1:0]   nv_d0_power,
   input  wire logic [wprl_pkg::DATA_W-1:0]   nv_d3_power,
   input  wire logic [wprl_pkg::SEL_W-1:0]    data_select,
   input  wire logic                          ctrl_wr,
   input  wire logic                          ctrl_legacy_wake_enable_bit,
   input  wire logic                          ctrl_assert_pme_on_legacy_wake,
   input  wire logic                          pme_en_wr,
   input  wire logic                          pme_en_wdata,
   input  wire logic                          pme_status_clr,
   input  wire logic                          status_wr,
   input  wire logic [NUM_FILT-1:0]           status_wdata,
   input  wire logic [NUM_FILT-1:0]           wake_filter_control,
   input  wire logic                          rx_valid,
   input  wire logic [wprl_pkg::DATA_W-1:0]   rx_data,
   input  wire logic                          rx_last,
   input  wire logic                          rx_addr_pass,
   input  wire logic                          rx_magic_match,
   input  wire logic [NUM_FILT-1:0]           rx_filter_match,
   input  wire logic                          link_up,
   input  wire logic [wprl_pkg::MEM_AW-1:0]   mem_rd_addr,
   output logic [wprl_pkg::DATA_W-1:0]        power_report_data,
   output logic [wprl_pkg::SCALE_W-1:0]       data_scale,
   output logic                               legacy_wake_enable,
   output logic                               assert_pme_on_legacy_wake,
   output logic                               pme_en,
   output logic                               pme_status,
   output logic [NUM_FILT-1:0]                wake_status_reg,
   output logic [wprl_pkg::LEN_W-1:0]         wake_frame_length,
   output logic [wprl_pkg::DATA_W-1:0]        mem_rd_data,
   output logic                               pme_n_o,
   output logic                               pme_n_oe,
   output logic                               legacy_wake_pin
);
   import wprl_pkg::*;

   localparam int CNT_W = $clog2(WAKE_PIN_CYCLES + 1);
   localparam logic [CNT_W-1:0] PIN_LOAD = CNT_W'(WAKE_PIN_CYCLES);
   localparam logic [LEN_W-1:0] KEEP_LIMIT = LEN_W'(FRAME_KEEP);
   localparam logic [LEN_W-1:0] LEN_MAX = '1;

   typedef struct packed {
      logic                 pm_enable;
      logic [DATA_W-1:0]    d0_power;
      logic [DATA_W-1:0]    d3_power;
      logic [DATA_W-1:0]    report;
      logic [SCALE_W-1:0]   scale;
      logic                 legacy_en;
      logic                 legacy_pme;
      logic                 pme_en;
      logic                 pme_status;
      logic                 pme_drive;
      logic                 pme_n;
      logic [NUM_FILT-1:0]  status;
      logic                 link_prev;
      logic                 link_armed;
      logic [LEN_W-1:0]     byte_cnt;
      logic [LEN_W-1:0]     frame_len;
      logic [CNT_W-1:0]     pin_cnt;
      logic                 pin;
      logic                 wr;
      logic [MEM_AW-1:0]    waddr;
      logic [DATA_W-1:0]    wdata;
   } wprl_state_t;

   wprl_state_t r;
   wprl_state_t next_r;

   wprl_cap_if #(.AW(MEM_AW), .DW(DATA_W)) cap ();

   wprl_frame_mem #(
      .DEPTH (FRAME_KEEP)
   ) u_mem (
      .sys_clk (sys_clk),
      .rst     (rst),
      .cap     (cap.mem)
   );

   logic                frames_locked;
   logic                legacy_hit;
   logic [NUM_FILT-1:0] frame_enable;
   logic [NUM_FILT-1:0] acpi_hits;
   logic                link_event;
   logic [LEN_W-1:0]    cnt_inc;

   always_comb begin
      // link bit is not a frame filter
      frame_enable = wake_filter_control;
      frame_enable[FILT_LINK] = 1'b0;
      frames_locked = |(r.status & ~(NUM_FILT'(1) << FILT_LINK));
      legacy_hit = rx_valid & rx_last & r.legacy_en & rx_magic_match & rx_addr_pass;
      acpi_hits = (rx_valid & rx_last & r.pme_en & rx_addr_pass)
                ? (rx_filter_match & frame_enable) : '0;
      link_event = r.link_armed & (link_up != r.link_prev)
                 & wake_filter_control[FILT_LINK] & ~r.status[FILT_LINK];
      cnt_inc = (r.byte_cnt == LEN_MAX) ? r.byte_cnt : r.byte_cnt + LEN_W'(1);
   end

   always_comb begin
      next_r = r;

      if (nv_load) begin
         next_r.pm_enable = nv_pm_enable;
         next_r.d0_power = nv_d0_power;
         next_r.d3_power = nv_d3_power;
         next_r.legacy_en = nv_legacy_wake_en;
      end
      if (ctrl_wr) begin
         next_r.legacy_en = ctrl_legacy_wake_enable_bit;
         next_r.legacy_pme = ctrl_assert_pme_on_legacy_wake;
      end
      // pme enable only takes a one when power management is on
      if (pme_en_wr) begin
         next_r.pme_en = pme_en_wdata & r.pm_enable;
      end
      if (pme_status_clr) begin
         next_r.pme_status = 1'b0;
      end
      // writing zero clears a status flag
      if (status_wr) begin
         next_r.status = r.status & status_wdata;
      end

      // capture path; memory is frozen while a wake frame is held
      next_r.wr = 1'b0;
      next_r.waddr = r.byte_cnt[MEM_AW-1:0];
      next_r.wdata = rx_data;
      if (rx_valid) begin
         // only the head and only while unlocked
         if ((r.byte_cnt < KEEP_LIMIT) && !frames_locked) begin
            next_r.wr = 1'b1;
         end
         next_r.byte_cnt = rx_last ? '0 : cnt_inc;
      end

      // frame sources: magic and network wake frames
      if (!frames_locked && (legacy_hit || (|acpi_hits))) begin
         next_r.status = next_r.status | acpi_hits;
         if (legacy_hit) begin
            next_r.status[FILT_MAGIC] = 1'b1;
         end
         // status set even with pme disabled
         next_r.pme_status = 1'b1;
         next_r.frame_len = cnt_inc;
      end

      next_r.link_prev = link_up;
      next_r.link_armed = 1'b1;
      if (link_event) begin
         next_r.status[FILT_LINK] = 1'b1;
         next_r.pme_status = 1'b1;
      end

      // pulse ignores magic frames while running
      next_r.pin_cnt = (r.pin_cnt != '0) ? r.pin_cnt - CNT_W'(1) : r.pin_cnt;
      if (HAS_WAKE_PIN && legacy_hit && (r.pin_cnt == '0)) begin
         next_r.pin_cnt = PIN_LOAD;
      end
      next_r.pin = (next_r.pin_cnt != '0);

      next_r.pme_drive = (next_r.status[FILT_MAGIC] & next_r.legacy_pme & next_r.legacy_en)
                       | (next_r.pme_status & next_r.pme_en);
      next_r.pme_n = ~next_r.pme_drive;

      next_r.report = REPORT_RST;
      next_r.scale = SCALE_UNKNOWN;
      if (r.pm_enable) begin
         unique case (data_select)
            SEL_D0_CONSUMED, SEL_D0_DISSIP: begin
               next_r.report = r.d0_power;
               // tenths of a watt for supported states
               next_r.scale = SCALE_TENTH;
            end
            SEL_D3_CONSUMED, SEL_D3_DISSIP: begin
               next_r.report = r.d3_power;
               next_r.scale = SCALE_TENTH;
            end
            // unsupported states and reserved codes read zero in unknown units
            default: begin
               next_r.report = REPORT_RST;
               next_r.scale = SCALE_UNKNOWN;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         r <= '0;
         r.pme_n <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign cap.wr = r.wr;
   assign cap.waddr = r.waddr;
   assign cap.wdata = r.wdata;
   assign cap.raddr = mem_rd_addr;

   assign power_report_data = r.report;
   assign data_scale = r.scale;
   assign legacy_wake_enable = r.legacy_en;
   assign assert_pme_on_legacy_wake = r.legacy_pme;
   assign pme_en = r.pme_en;
   assign pme_status = r.pme_status;
   assign wake_status_reg = r.status;
   assign wake_frame_length = r.frame_len;
   assign mem_rd_data = cap.rdata;
   assign pme_n_o = r.pme_n;
   assign pme_n_oe = r.pme_drive;
   assign legacy_wake_pin = r.pin;
endmodule

//--- core/wprl_frame_mem.sv
// wake frame memory holding the head of the captured frame
`timescale 1ns/1ps
module wprl_frame_mem #(
   parameter int DEPTH = wprl_pkg::FRAME_KEEP
) (
   input wire logic   sys_clk,
   input wire logic   rst,
   wprl_cap_if.mem    cap
);
   import wprl_pkg::*;

   typedef struct packed {
      logic [DEPTH-1:0][DATA_W-1:0] mem;
      logic [DATA_W-1:0]            rd;
   } wprl_mem_state_t;

   wprl_mem_state_t r;
   wprl_mem_state_t next_r;

   always_comb begin
      next_r = r;
      if (cap.wr) begin
         next_r.mem[cap.waddr] = cap.wdata;
      end
      next_r.rd = r.mem[cap.raddr];
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign cap.rdata = r.rd;
endmodule

//--- core/wprl_pkg.sv
// constants shared by the wakeup and power report logic
package wprl_pkg;
   localparam int          DATA_W          = 8;
   localparam int          SEL_W           = 4;
   localparam int          SCALE_W         = 2;
   localparam int          LEN_W           = 14;
   localparam int          FRAME_KEEP      = 128;
   localparam int          MEM_AW          = 7;
   localparam int          NUM_FILT        = 8;
   // status and filter control: bit 0 link change, bit 1 magic frame, above are frame filters
   localparam int          FILT_LINK       = 0;
   localparam int          FILT_MAGIC      = 1;
   localparam logic [3:0]  SEL_D0_CONSUMED = 4'h0;
   localparam logic [3:0]  SEL_D3_CONSUMED = 4'h3;
   localparam logic [3:0]  SEL_D0_DISSIP   = 4'h4;
   localparam logic [3:0]  SEL_D3_DISSIP   = 4'h7;
   localparam logic [3:0]  SEL_COMMON      = 4'h8;
   localparam logic [1:0]  SCALE_UNKNOWN   = 2'h0;
   localparam logic [1:0]  SCALE_TENTH     = 2'h1;
   localparam logic [1:0]  SCALE_HUNDREDTH = 2'h2;
   localparam logic [1:0]  SCALE_THOUSANDTH = 2'h3;
   localparam logic [7:0]  REPORT_RST      = 8'h00;
   localparam int          CLK_HZ          = 50000000;
   localparam int          WAKE_PIN_MS     = 50;
   localparam int          WAKE_PIN_CYCLES = CLK_HZ / 1000 * WAKE_PIN_MS;
endpackage

//--- sim/testbench.sv
// self-checking bench for the wakeup and power report logic
`timescale 1ns/1ps
module testbench;
   import wprl_pkg::*;
   localparam int PIN_CYC = 20;
   logic        sys_clk, rst, nv_load, nv_pm_enable, nv_legacy_wake_en, link_up;
   logic [7:0]  nv_d0_power, nv_d3_power, status_wdata, wake_filter_control, rx_data;
   logic [7:0]  rx_filter_match, power_report_data, wake_status_reg, mem_rd_data;
   logic        ctrl_wr, ctrl_legacy_wake_enable_bit, ctrl_assert_pme_on_legacy_wake;
   logic        pme_en_wr, pme_en_wdata, pme_status_clr, status_wr, rx_valid, rx_last;
   logic        rx_addr_pass, rx_magic_match, legacy_wake_enable, pme_line, pme_n_o;
   logic        assert_pme_on_legacy_wake, pme_en, pme_status, pme_n_oe, legacy_wake_pin;
   logic [3:0]  data_select;
   logic [6:0]  mem_rd_addr;
   logic [1:0]  data_scale;
   logic [13:0] wake_frame_length;
   logic [31:0] seed = 32'hB02B3131, e, r, want, exp_q [$];
   logic [7:0]  fbuf [FRAME_KEEP];
   logic [7:0]  k0, k127;
   int          kind_q [$], k, miscompares = 0, total_checks = 0;
   event        smp;
   wprl_core #(.WAKE_PIN_CYCLES(PIN_CYC)) uut (.*);
   wprl_host_model host (.pme_n_o(pme_n_o), .pme_n_oe(pme_n_oe), .pme_line(pme_line));
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [31:0] obs(int n);
      case (n)
         0: return 32'({data_scale, power_report_data});
         1: return 32'(wake_status_reg);
         2: return 32'(pme_status);
         3: return 32'(pme_line);
         4: return 32'(wake_frame_length);
         5: return 32'(mem_rd_data);
         6: return 32'(legacy_wake_enable);
         7: return 32'(pme_en);
         9: return 32'(assert_pme_on_legacy_wake);
         default: return 32'(legacy_wake_pin);
      endcase
   endfunction
   task tick(int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task note(int n, logic [31:0] v);
      kind_q.push_back(n);
      exp_q.push_back(v);
      -> smp;
   endtask
   // the watcher compares every pending note against the settled outputs
   initial forever begin
      @(smp);
      while (exp_q.size() > 0) begin
         k = kind_q.pop_front();
         want = exp_q.pop_front();
         total_checks++;
         if (obs(k) !== want) begin
            miscompares++;
            $display("Error %0t: item %0d got %h expected %h", $time, k, obs(k), want);
         end
      end
   end
   task nv(logic pm, logic lw);
      r = rnd();
      nv_load = 1'b1;
      nv_pm_enable = pm;
      nv_legacy_wake_en = lw;
      nv_d0_power = r[7:0];
      nv_d3_power = r[15:8];
      tick(1);
      nv_load = 1'b0;
   endtask
   // 0 pme enable, 1 status flags, 2 pme status clear, 3 wake control
   task wr(int w, logic [7:0] v);
      case (w)
         0: begin pme_en_wr = 1'b1; pme_en_wdata = v[0]; end
         1: begin status_wr = 1'b1; status_wdata = v; end
         2: pme_status_clr = 1'b1;
         default: begin ctrl_wr = 1'b1; ctrl_legacy_wake_enable_bit = v[0];
            ctrl_assert_pme_on_legacy_wake = v[1]; end
      endcase
      tick(1);
      {pme_en_wr, status_wr, pme_status_clr, ctrl_wr} = 4'h0;
      // one idle edge so the next write never re-raises a strobe in this time step
      tick(1);
   endtask
   task frame(int len, logic ap, logic mg, logic [7:0] fm);
      rx_addr_pass = ap;
      rx_magic_match = mg;
      rx_filter_match = fm;
      for (int i = 0; i < len; i++) begin
         r = rnd();
         rx_valid = 1'b1;
         rx_data = r[7:0];
         rx_last = (i == len - 1);
         if (i < FRAME_KEEP) fbuf[i] = r[7:0];
         tick(1);
      end
      {rx_valid, rx_last} = 2'h0;
      // gap between frames keeps rx_valid from being driven twice in one step
      tick(1);
   endtask
   task memchk(int a, logic [7:0] v);
      mem_rd_addr = a[6:0];
      tick(2);
      note(5, 32'(v));
   endtask
   task tally_and_finish;
      if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (4000) @(posedge sys_clk);
      miscompares++;
      tally_and_finish();
   end
   initial begin
      {nv_load, nv_pm_enable, nv_legacy_wake_en, ctrl_wr, link_up} = 5'h0;
      {ctrl_legacy_wake_enable_bit, ctrl_assert_pme_on_legacy_wake, pme_en_wr} = 3'h0;
      {pme_en_wdata, pme_status_clr, status_wr, rx_valid, rx_last} = 5'h0;
      {rx_addr_pass, rx_magic_match, data_select, mem_rd_addr} = 13'h0;
      {nv_d0_power, nv_d3_power, status_wdata, wake_filter_control} = 32'h0;
      {rx_data, rx_filter_match} = 16'h0;
      rst = 1'b1;
      tick(8);
      rst = 1'b0;
      note(3, 32'h1);
      for (int pm = 0; pm < 2; pm++) begin
         nv(pm[0], 1'b1);
         note(6, 32'h1);
         if (pm == 0) wr(0, 8'h01);
         note(7, 32'h0);
         for (int s = 0; s < 16; s++) begin
            data_select = s[3:0];
            tick(1);
            e = 32'h0;
            if (pm == 1 && (s == 0 || s == 4)) e = {22'h0, SCALE_TENTH, nv_d0_power};
            if (pm == 1 && (s == 3 || s == 7)) e = {22'h0, SCALE_TENTH, nv_d3_power};
            note(0, e);
         end
      end
      wr(3, 8'h03);
      note(9, 32'h1);
      frame(130, 1'b1, 1'b1, 8'h00);
      k0 = fbuf[0];
      k127 = fbuf[127];
      note(1, 32'h02);
      note(2, 32'h1);
      note(3, 32'h0);
      note(4, 32'd130);
      note(8, 32'h1);
      frame(4, 1'b1, 1'b1, 8'h0C);
      note(4, 32'd130);
      memchk(0, k0);
      memchk(127, k127);
      tick(PIN_CYC);
      note(8, 32'h0);
      frame(4, 1'b1, 1'b1, 8'h00);
      note(8, 32'h1);
      wr(1, 8'hFD);
      note(1, 32'h00);
      note(3, 32'h1);
      wr(2, 8'h00);
      note(2, 32'h0);
      wr(3, 8'h00);
      frame(20, 1'b1, 1'b1, 8'h00);
      note(6, 32'h0);
      note(1, 32'h00);
      wr(0, 8'h01);
      note(7, 32'h1);
      wake_filter_control = 8'h0C;
      frame(64, 1'b0, 1'b0, 8'h0C);
      note(1, 32'h00);
      note(4, 32'd130);
      frame(64, 1'b1, 1'b0, 8'h1C);
      note(1, 32'h0C);
      note(3, 32'h0);
      note(4, 32'd64);
      wr(2, 8'h00);
      note(3, 32'h1);
      wr(1, 8'hF3);
      note(1, 32'h00);
      wake_filter_control = 8'h01;
      link_up = 1'b1;
      tick(2);
      note(1, 32'h01);
      note(3, 32'h0);
      wr(0, 8'h00);
      note(3, 32'h1);
      wr(2, 8'h00);
      wr(0, 8'h01);
      link_up = 1'b0;
      tick(2);
      note(2, 32'h0);
      wr(1, 8'hFE);
      note(1, 32'h00);
      wr(0, 8'h00);
      wr(3, 8'h01);
      note(9, 32'h0);
      frame(8, 1'b1, 1'b1, 8'h00);
      note(1, 32'h02);
      note(2, 32'h1);
      note(3, 32'h1);
      tick(2);
      tally_and_finish();
   end
endmodule
bind wprl_core wprl_core_asserts #(.NUM_FILT(NUM_FILT), .WAKE_PIN_CYCLES(WAKE_PIN_CYCLES)) chk (.*);

//--- sim/wprl_core_asserts.sv
// concurrent checks on the wakeup and power report ports
`timescale 1ns/1ps
module wprl_core_asserts
   import wprl_pkg::*;
#(
   parameter int unsigned NUM_FILT        = wprl_pkg::NUM_FILT,
   parameter int unsigned WAKE_PIN_CYCLES = wprl_pkg::WAKE_PIN_CYCLES
) (
   input wire logic                        sys_clk,
   input wire logic                        rst,
   input wire logic [wprl_pkg::SEL_W-1:0]  data_select,
   input wire logic [wprl_pkg::DATA_W-1:0] power_report_data,
   input wire logic [wprl_pkg::SCALE_W-1:0] data_scale,
   input wire logic                        status_wr,
   input wire logic [NUM_FILT-1:0]         status_wdata,
   input wire logic                        pme_status_clr,
   input wire logic                        rx_valid,
   input wire logic                        rx_last,
   input wire logic                        rx_addr_pass,
   input wire logic                        rx_magic_match,
   input wire logic                        legacy_wake_enable,
   input wire logic                        assert_pme_on_legacy_wake,
   input wire logic                        pme_en,
   input wire logic                        pme_status,
   input wire logic [NUM_FILT-1:0]         wake_status_reg,
   input wire logic [wprl_pkg::LEN_W-1:0]  wake_frame_length,
   input wire logic                        pme_n_o,
   input wire logic                        pme_n_oe,
   input wire logic                        legacy_wake_pin
);
   import wprl_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   int unsigned pin_cnt;
   logic        legacy_cause;
   assign legacy_cause = wake_status_reg[FILT_MAGIC] && assert_pme_on_legacy_wake
                         && legacy_wake_enable;
   // counts sampled high cycles of the wake pin pulse
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) pin_cnt <= 0;
      else if (legacy_wake_pin) pin_cnt <= pin_cnt + 1;
      else pin_cnt <= 0;
   end
   a_unused_sel_zero: assert property (
      !(data_select inside {4'h0, 4'h3, 4'h4, 4'h7}) |=>
      (power_report_data == 8'h00) && (data_scale == SCALE_UNKNOWN))
      else $error("report not zero for an unused select");
   a_scale_tenths: assert property (
      (data_scale != SCALE_UNKNOWN) |->
      (data_scale == SCALE_TENTH) && ($past(data_select) inside {4'h0, 4'h3, 4'h4, 4'h7}))
      else $error("scale field wrong for select");
   a_legacy_pme_on: assert property (
      legacy_cause |-> ##[0:1] pme_n_oe) else $error("pme not driven after legacy wake");
   a_acpi_pme_on: assert property (
      (pme_status && pme_en) |-> ##[0:1] pme_n_oe) else $error("pme not driven on status");
   a_pme_released: assert property (
      (!legacy_cause && !(pme_status && pme_en)) [*2] |-> !pme_n_oe)
      else $error("pme driven without a cause");
   a_pme_drives_low: assert property (
      pme_n_oe |-> !pme_n_o) else $error("pme driven high");
   a_magic_flag_hold: assert property (
      $fell(wake_status_reg[FILT_MAGIC]) |->
      $past(status_wr) && !$past(status_wdata[FILT_MAGIC]))
      else $error("magic flag cleared without a write");
   a_status_hold: assert property (
      $fell(pme_status) |-> $past(pme_status_clr)) else $error("pme status lost");
   a_len_after_last: assert property (
      $changed(wake_frame_length) |-> $past(rx_valid && rx_last))
      else $error("length changed outside a frame end");
   a_frames_ignored: assert property (
      (|wake_status_reg[NUM_FILT-1:1]) && rx_valid && rx_last && !status_wr |=>
      $stable(wake_frame_length)) else $error("frame taken while flags set");
   a_pin_width: assert property (
      $fell(legacy_wake_pin) |-> pin_cnt == WAKE_PIN_CYCLES)
      else $error("wake pin pulse width wrong");
   a_pin_on_magic: assert property (
      rx_valid && rx_last && rx_magic_match && rx_addr_pass && legacy_wake_enable
      && !legacy_wake_pin |=> legacy_wake_pin) else $error("wake pin not raised");
   cover property (legacy_cause);
   cover property ($rose(wake_status_reg[FILT_LINK]));
   cover property ($rose(wake_status_reg[2]) && wake_status_reg[3]);
endmodule

//--- sim/wprl_host_model.sv
// host side of the pme line: pulled up whenever no device drives it
`timescale 1ns/1ps
module wprl_host_model (
   input  wire logic pme_n_o,
   input  wire logic pme_n_oe,
   output logic      pme_line
);
   // line low only while the device drives it
   assign pme_line = pme_n_oe ? pme_n_o : 1'b1;
endmodule
